// ### hdl/art_timer.sv
// 8-bit auto-reload pwm timer with prescaler, four pwm outputs and two captures
`timescale 1ns/1ns
// ------------------------------------------------------------
// Behaviour
// RL1 - capture edge raises that channel's interrupt
// RL2 - enabled capture edge wakes from deep halt
// RL3 - control bit 7 selects external prescaler clock
// RL4 - bits 6:4 divide input by power two
// RL5 - run bit 0 freezes prescaler and counter
// RL6 - force bit loads reload, clears prescaler, reads 0
// RL7 - overflow irq needs flag and enable
// RL8 - overflow sets flag; control read clears it
// RL9 - counter register reads live, writes load
// RL10 - reload value copied into counter at overflow
// RL11 - overflow puts pwm outputs at period start
// RL12 - pwm control bits 7:4 enable outputs
// RL13 - polarity bits 3:0 set pwm level sense
// RL14 - polarity change inverts output at once
// RL15 - duty value sets second pwm edge
// RL16 - capture control bits 7:6 read zero
// RL17 - capture edge select: 0 falling, 1 rising
// RL18 - capture interrupt enables per channel
// RL19 - software reads flags to find source
// RL20 - all registers clear to zero on reset
// RL21 - shared period is 256 minus reload
// RL22 - hidden compare loads from duty at overflow
// RL23 - capture sets flag; data read clears it
// RL24 - full capture register blocks further captures
// RL25 - external inputs synchronised and edge detected
// ------------------------------------------------------------
module art_timer #(
    parameter int PWM_CH = 4, // pwm channels
    parameter int CAP_CH = 2 // capture channels
) (
    input wire logic core_clk, // cpu clock
    input wire logic sys_rst, // async reset, active high
    input wire logic [7:0] reg_addr, // register offset
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [7:0] reg_rdata, // read data, cycle after strobe
    input wire logic ext_clk_in, // external prescaler clock
    input wire logic [CAP_CH-1:0] capture_input_pin, // capture inputs
    input wire logic deep_halt, // processor is in deep halt
    output logic [PWM_CH-1:0] pwm_output_pin, // pwm levels
    output logic [PWM_CH-1:0] pwm_output_oe, // pwm pin drive enable
    output logic overflow_irq, // overflow interrupt request
    output logic [CAP_CH-1:0] capture_irq, // capture interrupt requests
    output logic halt_wake // wake pulse during deep halt
);
    import art_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] csr_ctl; // control bits, force and flag kept apart
    logic overflow_flag;
    logic [7:0] counter;
    logic [6:0] prescaler;
    logic [7:0] auto_reload_value;
    logic [7:0] pwm_output_control;
    logic [7:0] duty_cycle_value [PWM_CH];
    logic [7:0] hidden_compare_value [PWM_CH];
    logic [1:0] capture_edge_select;
    logic [1:0] capture_irq_enable_field;
    logic [CAP_CH-1:0] capture_flag;
    logic [7:0] capture_data_reg [CAP_CH];
    logic [2:0] ext_sync;
    logic [2:0] cap_sync [CAP_CH];

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic ext_clock_select;
    logic [2:0] counter_clock_divider;
    logic counter_run_enable;
    logic overflow_irq_enable;
    logic wr_csr;
    logic rd_csr;
    logic wr_cnt;
    logic force_reload;
    logic ext_rise;
    logic in_tick;
    logic [6:0] div_mask;
    logic count_tick;
    logic overflow_evt;
    logic [CAP_CH-1:0] cap_edge;
    logic [CAP_CH-1:0] cap_rd;

    assign ext_clock_select = csr_ctl[BIT_EXT_CLK];
    assign counter_clock_divider = csr_ctl[BIT_DIV_HI:BIT_DIV_LO];
    assign counter_run_enable = csr_ctl[BIT_RUN];
    assign overflow_irq_enable = csr_ctl[BIT_OVF_IE];
    assign wr_csr = reg_wr && reg_addr == OFS_TIMER_CSR;
    assign rd_csr = reg_rd && reg_addr == OFS_TIMER_CSR;
    assign wr_cnt = reg_wr && reg_addr == OFS_COUNTER;
    assign force_reload = wr_csr && reg_wdata[BIT_FORCE]; // RL6

    // ------------------------------------------------------------
    // input synchronisers and edge detect
    // ------------------------------------------------------------
    // stage 0 feeds only stage 1; edges compare stages 1 and 2
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ext_sync <= 3'h0;
        end else begin
            ext_sync <= {ext_sync[1:0], ext_clk_in}; // RL25
        end
    end
    assign ext_rise = ext_sync[1] && !ext_sync[2]; // RL25

    generate
        for (genvar c = 0; c < CAP_CH; c++) begin : g_cap_sync
            always_ff @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    cap_sync[c] <= 3'h0;
                end else begin
                    cap_sync[c] <= {cap_sync[c][1:0], capture_input_pin[c]}; // RL25
                end
            end
            // programmed edge: rising when select is 1, falling when 0
            assign cap_edge[c] = capture_edge_select[c]
                ? (cap_sync[c][1] && !cap_sync[c][2])
                : (!cap_sync[c][1] && cap_sync[c][2]); // RL17
        end
    endgenerate

    // ------------------------------------------------------------
    // prescaler and counter timing
    // ------------------------------------------------------------
    // divide by 2^n: counter steps when the low n prescaler bits are all ones
    assign in_tick = ext_clock_select ? ext_rise : 1'b1; // RL3
    assign div_mask = PRESC_ALL >> (DIV_MAX - counter_clock_divider); // RL4
    assign count_tick = counter_run_enable && in_tick
        && ((prescaler & div_mask) == div_mask); // RL4 RL5
    assign overflow_evt = count_tick && counter == CNT_TOP;

    // prescaler frees only while running; loads of the counter restart it
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prescaler <= RST_PRESC; // RL20
        end else if (force_reload || wr_cnt) begin
            prescaler <= RST_PRESC; // RL6
        end else if (counter_run_enable && in_tick) begin
            prescaler <= prescaler + 7'h01; // RL5
        end
    end

    // software loads take priority over the count step in the same cycle
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            counter <= RST_REG; // RL20
        end else if (wr_cnt) begin
            counter <= reg_wdata; // RL9
        end else if (force_reload) begin
            counter <= auto_reload_value; // RL6
        end else if (overflow_evt) begin
            counter <= auto_reload_value; // RL10 RL21
        end else if (count_tick) begin
            counter <= counter + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // control / status register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            csr_ctl <= RST_REG; // RL20
        end else if (wr_csr) begin
            csr_ctl <= reg_wdata & 8'hFA; // force and flag are not stored
        end
    end

    // a read clears the flag, but an overflow in the same cycle wins
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            overflow_flag <= 1'b0; // RL20
        end else if (overflow_evt) begin
            overflow_flag <= 1'b1; // RL8
        end else if (rd_csr) begin
            overflow_flag <= 1'b0; // RL8
        end
    end
    assign overflow_irq = overflow_flag && overflow_irq_enable; // RL7

    // ------------------------------------------------------------
    // reload, pwm control and duty registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            auto_reload_value <= RST_REG; // RL20
            pwm_output_control <= RST_REG;
        end else if (reg_wr) begin
            if (reg_addr == OFS_RELOAD) begin
                auto_reload_value <= reg_wdata;
            end
            if (reg_addr == OFS_PWM_CTL) begin
                pwm_output_control <= reg_wdata;
            end
        end
    end

    // duty registers sit at descending offsets, channel 0 highest
    generate
        for (genvar p = 0; p < PWM_CH; p++) begin : g_pwm
            localparam logic [7:0] DUTY_OFS = OFS_DUTY0 - 8'(p);
            always_ff @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    duty_cycle_value[p] <= RST_REG; // RL20
                end else if (reg_wr && reg_addr == DUTY_OFS) begin
                    duty_cycle_value[p] <= reg_wdata; // RL15
                end
            end
            // double buffer: compare changes only at overflow, no glitch
            always_ff @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    hidden_compare_value[p] <= RST_REG;
                end else if (overflow_evt) begin
                    hidden_compare_value[p] <= duty_cycle_value[p]; // RL22
                end
            end
            // level follows live counter and polarity each cycle, so the
            // period start lands right after the reload and a polarity
            // write shows on the very next edge
            always_ff @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    pwm_output_pin[p] <= 1'b0;
                end else begin
                    pwm_output_pin[p] <= pwm_output_control[BIT_PWM_EN + p]
                        && ((counter <= hidden_compare_value[p])
                        ^ pwm_output_control[p]); // RL11 RL13 RL14 RL15
                end
            end
            assign pwm_output_oe[p] = pwm_output_control[BIT_PWM_EN + p]; // RL12
        end
    endgenerate

    // ------------------------------------------------------------
    // input capture
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            capture_edge_select <= 2'h0; // RL20
            capture_irq_enable_field <= 2'h0;
        end else if (reg_wr && reg_addr == OFS_CAP_CSR) begin
            capture_edge_select <= reg_wdata[BIT_CAP_EDGE +: 2]; // RL17
            capture_irq_enable_field <= reg_wdata[BIT_CAP_IE +: 2]; // RL18
        end
    end

    generate
        for (genvar c = 0; c < CAP_CH; c++) begin : g_cap
            localparam logic [7:0] CAP_OFS = OFS_CAP_DATA1 + 8'(c);
            assign cap_rd[c] = reg_rd && reg_addr == CAP_OFS;
            // latch while empty or during a data read; a read in the same cycle as a new
            // edge leaves the flag set since the set wins
            always_ff @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    capture_flag[c] <= 1'b0; // RL20
                    capture_data_reg[c] <= RST_REG;
                end else if (cap_edge[c] && (!capture_flag[c] || cap_rd[c])) begin
                    capture_flag[c] <= 1'b1; // RL23
                    capture_data_reg[c] <= counter; // RL24
                end else if (cap_rd[c]) begin
                    capture_flag[c] <= 1'b0; // RL23
                end
            end
            assign capture_irq[c] = capture_flag[c] && capture_irq_enable_field[c]; // RL1 RL18
        end
    endgenerate

    // wake is a pulse on an enabled edge while halted
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            halt_wake <= 1'b0;
        end else begin
            halt_wake <= deep_halt && |(cap_edge & capture_irq_enable_field); // RL2
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    logic [7:0] next_rdata;
    always_comb begin
        next_rdata = 8'h00;
        unique case (reg_addr)
            OFS_TIMER_CSR: next_rdata = csr_ctl | {7'h00, overflow_flag}; // RL6
            OFS_COUNTER: next_rdata = counter; // RL9
            OFS_RELOAD: next_rdata = auto_reload_value;
            OFS_PWM_CTL: next_rdata = pwm_output_control;
            OFS_DUTY0: next_rdata = duty_cycle_value[0];
            OFS_DUTY1: next_rdata = duty_cycle_value[1];
            OFS_DUTY2: next_rdata = duty_cycle_value[2];
            OFS_DUTY3: next_rdata = duty_cycle_value[3];
            OFS_CAP_CSR: next_rdata = {2'h0, capture_edge_select,
                capture_irq_enable_field, capture_flag}; // RL16
            OFS_CAP_DATA1: next_rdata = capture_data_reg[0];
            OFS_CAP_DATA2: next_rdata = capture_data_reg[1];
            default: next_rdata = 8'h00; // unmapped reads zero
        endcase
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= RST_REG;
        end else begin
            reg_rdata <= reg_rd ? next_rdata : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_overflow;
        overflow_evt && !wr_cnt && !force_reload;
    endsequence
    sequence s_reload_done;
        counter == $past(auto_reload_value);
    endsequence

    a_overflow_flag_set: assert property (overflow_evt |=> overflow_flag) // RL8
        else $error("overflow did not set flag");
    a_counter_reload: assert property (s_overflow |=> s_reload_done) // RL10
        else $error("counter not reloaded at overflow");
    a_counter_frozen: assert property (!counter_run_enable && !wr_cnt && !force_reload
        |=> $stable(counter) && $stable(prescaler)) // RL5
        else $error("counter moved while stopped");
    a_force_reload_init: assert property (force_reload && !wr_cnt
        |=> s_reload_done and prescaler == RST_PRESC) // RL6
        else $error("force reload failed");
    a_force_reads_zero: assert property (rd_csr |=> !reg_rdata[BIT_FORCE]) // RL6
        else $error("force bit read as one");
    a_flag_read_clear: assert property (rd_csr && !overflow_evt |=> !overflow_flag
        ##0 !overflow_irq) // RL7
        else $error("flag survived control read");
    a_compare_load: assert property (overflow_evt
        |=> hidden_compare_value[0] == $past(duty_cycle_value[0])) // RL22
        else $error("compare not loaded at overflow");
    a_pwm_level: assert property (##1 pwm_output_pin[0] == // RL13
        ($past(pwm_output_control[4]) && (($past(counter) <= $past(hidden_compare_value[0]))
        ^ $past(pwm_output_control[0]))))
        else $error("pwm level mismatch");
    // a disabled channel must sit low so nothing leaks out when the pin is released
    a_pwm_off_low: assert property (!pwm_output_control[BIT_PWM_EN] // RL12
        |=> !pwm_output_pin[0])
        else $error("disabled pwm channel not low");
    // polarity write alone, with counter and compare still, must flip the pin next edge
    sequence s_polarity_only;
        $changed(pwm_output_control[0]) && pwm_output_control[4]
            && $stable(pwm_output_control[4]) && $stable(counter)
            && $stable(hidden_compare_value[0]);
    endsequence
    a_polarity_flip: assert property (s_polarity_only // RL14
        |=> pwm_output_pin[0] != $past(pwm_output_pin[0]))
        else $error("polarity change did not invert pwm");
    a_capture_latch: assert property (cap_edge[0] && !capture_flag[0]
        |=> capture_flag[0] && capture_data_reg[0] == $past(counter)) // RL23
        else $error("capture not latched");
    a_capture_blocked: assert property (capture_flag[0] && !cap_rd[0]
        |=> $stable(capture_data_reg[0]) && capture_flag[0]) // RL24
        else $error("capture overwritten while full");
    a_reserved_zero: assert property (reg_rd && reg_addr == OFS_CAP_CSR
        |=> reg_rdata[7:6] == 2'h0) // RL16
        else $error("reserved capture bits nonzero");
    a_halt_wake: assert property (deep_halt && cap_edge[0] && capture_irq_enable_field[0]
        |=> halt_wake) // RL2
        else $error("no wake on enabled capture edge");

endmodule : art_timer

// ### hdl/art_pkg.sv
// constants shared by the auto-reload pwm timer
package art_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_DUTY3 = 8'h73;
    localparam logic [7:0] OFS_DUTY2 = 8'h74;
    localparam logic [7:0] OFS_DUTY1 = 8'h75;
    localparam logic [7:0] OFS_DUTY0 = 8'h76;
    localparam logic [7:0] OFS_PWM_CTL = 8'h77;
    localparam logic [7:0] OFS_TIMER_CSR = 8'h78;
    localparam logic [7:0] OFS_COUNTER = 8'h79;
    localparam logic [7:0] OFS_RELOAD = 8'h7A;
    localparam logic [7:0] OFS_CAP_CSR = 8'h7B;
    localparam logic [7:0] OFS_CAP_DATA1 = 8'h7C;
    localparam logic [7:0] OFS_CAP_DATA2 = 8'h7D;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_EXT_CLK = 7;
    localparam int BIT_DIV_HI = 6;
    localparam int BIT_DIV_LO = 4;
    localparam int BIT_RUN = 3;
    localparam int BIT_FORCE = 2;
    localparam int BIT_OVF_IE = 1;
    localparam int BIT_OVF = 0;
    localparam int BIT_CAP_EDGE = 4;
    localparam int BIT_CAP_IE = 2;
    localparam int BIT_CAP_FLAG = 0;
    localparam int BIT_PWM_EN = 4;
    // ------------------------------------------------------------
    // reset values and sizes
    // ------------------------------------------------------------
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [6:0] RST_PRESC = 7'h00;
    localparam logic [7:0] CNT_TOP = 8'hFF;
    localparam logic [6:0] PRESC_ALL = 7'h7F;
    localparam logic [2:0] DIV_MAX = 3'h7;
endpackage : art_pkg

// ### sim/art_edge_source.sv
// far-side model: capture pins and bursts on the external clock pin
`timescale 1ns/1ns
module art_edge_source (
    input wire logic core_clk, // cpu clock
    input wire logic [1:0] cap_level, // requested capture pin levels
    input wire logic ext_go, // one-cycle start of a pulse burst
    input wire logic [7:0] ext_count, // pulses in the burst
    output logic [1:0] capture_input_pin, // capture pins toward the timer
    output logic ext_clk_in // external clock, low between bursts
);
    logic [1:0] pin_q = 2'b00;
    logic [10:0] phase = 11'h000;
    logic busy = 1'b0;
    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    // pins change only at clock edges, like a real source sampled on board
    always_ff @(posedge core_clk) begin
        pin_q <= cap_level;
        if (ext_go) begin
            busy <= 1'b1;
            phase <= 11'h000;
        end else if (busy) begin
            phase <= phase + 11'h001;
            // last phase of the final low half, so exactly ext_count pulses leave
            if (phase == {ext_count, 3'h0} - 11'h001) begin
                busy <= 1'b0;
            end
        end
    end
    // four cycles high, four low: slow enough for a two-stage synchroniser
    assign ext_clk_in = busy & ~phase[2];
    assign capture_input_pin = pin_q;
endmodule : art_edge_source

// ### sim/art_timer_bench.sv
// self-checking bench for the auto-reload pwm timer
`timescale 1ns/1ns
module art_timer_bench;
    import art_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic deep_halt = 1'b0;
    logic [1:0] cap_level = 2'b00;
    logic ext_go = 1'b0;
    logic [7:0] ext_count = 8'h00;
    logic [7:0] reg_rdata;
    logic ext_clk_in;
    logic [1:0] capture_input_pin;
    logic [3:0] pwm_output_pin;
    logic [3:0] pwm_output_oe;
    logic overflow_irq;
    logic [1:0] capture_irq;
    logic halt_wake;
    int err_count = 0;
    int n_tests = 0;
    int wake_cnt = 0;
    logic [7:0] v;
    logic [3:0] ep;
    logic [7:0] duty [4] = '{8'h40, 8'h08, 8'h80, 8'h10};

    always #5 core_clk = ~core_clk;

    art_timer art_timer_inst (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ext_clk_in(ext_clk_in), .capture_input_pin(capture_input_pin),
        .deep_halt(deep_halt), .pwm_output_pin(pwm_output_pin),
        .pwm_output_oe(pwm_output_oe), .overflow_irq(overflow_irq),
        .capture_irq(capture_irq), .halt_wake(halt_wake));

    art_edge_source art_edge_source_inst (.core_clk(core_clk), .cap_level(cap_level),
        .ext_go(ext_go), .ext_count(ext_count), .capture_input_pin(capture_input_pin),
        .ext_clk_in(ext_clk_in));

    // wake pulses are one cycle wide, so count them at every edge
    always @(posedge core_clk) if (halt_wake === 1'b1) wake_cnt++;

    // ------------------------------------------------------------
    // access and compare tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        check(d, exp);
    endtask : rd_chk

    task automatic test_done;
        if (err_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    // a hang must not stall the regression
    initial begin
        #200000;
        err_count++;
        test_done;
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int a = 8'h73; a <= 8'h7D; a++) rd_chk(a[7:0], RST_REG);
        rd_chk(8'h80, 8'h00);
        wr(OFS_CAP_CSR, 8'hFF);
        rd_chk(OFS_CAP_CSR, 8'h3C);
        // counter load and freeze while stopped
        wr(OFS_COUNTER, 8'h10);
        repeat (20) @(posedge core_clk);
        rd_chk(OFS_COUNTER, 8'h10);
        wr(OFS_RELOAD, 8'hF0);
        wr(OFS_TIMER_CSR, 8'h04);
        rd_chk(OFS_COUNTER, 8'hF0);
        rd_chk(OFS_TIMER_CSR, 8'h00);
        // overflow flag and its interrupt
        wr(OFS_RELOAD, 8'hFE);
        wr(OFS_COUNTER, 8'hFD);
        wr(OFS_TIMER_CSR, 8'h0A);
        repeat (10) @(posedge core_clk);
        wr(OFS_TIMER_CSR, 8'h02);
        check({7'h00, overflow_irq}, 8'h01);
        rd_chk(OFS_TIMER_CSR, 8'h03);
        rd_chk(OFS_TIMER_CSR, 8'h02);
        check({7'h00, overflow_irq}, 8'h00);
        // every divider code over a fixed window, two steps of slack for latency
        wr(OFS_RELOAD, 8'h00);
        for (int n = 0; n < 8; n++) begin
            wr(OFS_COUNTER, 8'h00);
            wr(OFS_TIMER_CSR, {1'b0, n[2:0], 4'h8});
            repeat (128) @(posedge core_clk);
            wr(OFS_TIMER_CSR, 8'h00);
            rd(OFS_COUNTER, v);
            check({7'h00, v >= (8'd128 >> n) && v <= (8'd128 >> n) + 8'd2}, 8'h01);
        end
        // external clock: five pulses give five counts
        wr(OFS_COUNTER, 8'h00);
        wr(OFS_TIMER_CSR, 8'h88);
        ext_count <= 8'h05;
        ext_go <= 1'b1;
        @(posedge core_clk);
        ext_go <= 1'b0;
        repeat (60) @(posedge core_clk);
        wr(OFS_TIMER_CSR, 8'h00);
        rd_chk(OFS_COUNTER, 8'h05);
        // pwm: duties reach the compare only through an overflow
        for (int i = 0; i < 4; i++) wr(OFS_DUTY0 - 8'(i), duty[i]);
        wr(OFS_PWM_CTL, 8'hF0);
        wr(OFS_COUNTER, 8'hF0);
        wr(OFS_TIMER_CSR, 8'h08);
        repeat (40) @(posedge core_clk);
        wr(OFS_TIMER_CSR, 8'h00);
        rd(OFS_COUNTER, v);
        // 16 steps from F0 wrap through 00, then 26 more before the stop lands
        check(v, 8'h1A);
        wr(OFS_DUTY0, 8'h00);
        repeat (3) @(posedge core_clk);
        for (int i = 0; i < 4; i++) ep[i] = 8'h1A <= duty[i];
        check({4'h0, pwm_output_oe}, 8'h0F);
        check({4'h0, pwm_output_pin}, {4'h0, ep});
        wr(OFS_PWM_CTL, 8'hF5);
        repeat (2) @(posedge core_clk);
        check({4'h0, pwm_output_pin}, {4'h0, ep ^ 4'h5});
        wr(OFS_PWM_CTL, 8'h35);
        repeat (2) @(posedge core_clk);
        check({pwm_output_oe, pwm_output_pin}, {4'h3, 2'b00, ep[1:0] ^ 2'b01});
        // capture channel 1 on a rising edge, then blocked until its data read
        wr(OFS_COUNTER, 8'h55);
        wr(OFS_CAP_CSR, 8'h14);
        cap_level <= 2'b01;
        repeat (6) @(posedge core_clk);
        check({6'h00, capture_irq}, 8'h01);
        rd_chk(OFS_CAP_CSR, 8'h15);
        wr(OFS_COUNTER, 8'h66);
        cap_level <= 2'b00;
        repeat (6) @(posedge core_clk);
        cap_level <= 2'b01;
        repeat (6) @(posedge core_clk);
        rd_chk(OFS_CAP_DATA1, 8'h55);
        rd_chk(OFS_CAP_CSR, 8'h14);
        check({6'h00, capture_irq}, 8'h00);
        // channel 2 on a falling edge while the processor sleeps
        wr(OFS_CAP_CSR, 8'h08);
        cap_level <= 2'b11;
        repeat (6) @(posedge core_clk);
        rd_chk(OFS_CAP_CSR, 8'h08);
        deep_halt <= 1'b1;
        cap_level <= 2'b01;
        repeat (6) @(posedge core_clk);
        deep_halt <= 1'b0;
        check(8'(wake_cnt), 8'h01);
        check({6'h00, capture_irq}, 8'h02);
        rd_chk(OFS_CAP_CSR, 8'h0A);
        rd_chk(OFS_CAP_DATA2, 8'h66);
        rd_chk(OFS_CAP_CSR, 8'h08);
        test_done;
    end
endmodule : art_timer_bench
